/* psi_evt_if.sv */
// Event flags and interrupt controls passed between the block's modules
`timescale 1ns/1ps
interface psi_evt_if;
	logic [3:0] flags;
	logic [3:0] mask;
	logic       global_irq_enable;
	logic       irq_force_test;
	logic       pending;
	logic       irq_n;

	modport evt (output flags);
	modport ctl (input flags, input pending, input irq_n,
		output mask, output global_irq_enable, output irq_force_test);
	modport irq (input flags, input mask, input global_irq_enable, input irq_force_test,
		output pending, output irq_n);
endinterface

/* psi_evt_latch.sv */
// Change detection and read-clearing event flags
`timescale 1ns/1ps
`include "psi_map.svh"
module psi_evt_latch (
	// Clock and reset
	input  wire logic clk_sys,
	input  wire logic arst_n,
	input  wire logic ce,
	// Line state
	input  wire logic an_complete,
	input  wire logic speed_100,
	input  wire logic duplex_full,
	input  wire logic link_up,
	// Read of the event register
	input  wire logic clear,
	// Flags out
	psi_evt_if.evt    ev
);
	import psi_pkg::*;

	psi_evt_s st;
	psi_evt_s next_st;
	psi_evt_t hit;

	always_comb begin
		next_st = st;
		hit = 4'h0;
		if (st.primed) begin
			hit[`PSI_I_AN]     = an_complete & ~st.prev_an;
			hit[`PSI_I_SPEED]  = speed_100 ^ st.prev_speed;
			hit[`PSI_I_DUPLEX] = duplex_full ^ st.prev_duplex;
			hit[`PSI_I_LINK]   = link_up ^ st.prev_link;
		end
		next_st.primed      = 1'b1;
		next_st.prev_an     = an_complete;
		next_st.prev_speed  = speed_100;
		next_st.prev_duplex = duplex_full;
		next_st.prev_link   = link_up;
		// A new event in the clearing cycle survives the read
		next_st.flags = (clear ? 4'h0 : st.flags) | hit;
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			st <= '0;
		end else if (ce) begin
			st <= next_st;
		end
	end

	assign ev.flags = st.flags;

	// ************************************************************
	// Checks
	// ************************************************************
	sequence s_speed_moves;
		ce && st.primed && (speed_100 != st.prev_speed);
	endsequence

	sequence s_quiet_read;
		ce && clear && (hit == 4'h0);
	endsequence

	a_speed_latch: assert property (@(posedge clk_sys) disable iff (!arst_n)
		s_speed_moves |=> st.flags[`PSI_I_SPEED])
		else $error("speed change not latched");

	a_flags_cleared: assert property (@(posedge clk_sys) disable iff (!arst_n)
		s_quiet_read |=> (st.flags == 4'h0))
		else $error("event read did not clear flags");

	a_link_hold: assert property (@(posedge clk_sys) disable iff (!arst_n)
		ce && st.flags[`PSI_I_LINK] && !clear |=> st.flags[`PSI_I_LINK])
		else $error("link flag lost before read");

	a_done_latch: assert property (@(posedge clk_sys) disable iff (!arst_n)
		ce && st.primed && an_complete && !st.prev_an |=> st.flags[`PSI_I_AN])
		else $error("negotiation done not latched");

endmodule // psi_evt_latch

/* psi_irq_gen.sv */
// Interrupt gating, pending status and active-low output
`timescale 1ns/1ps
`include "psi_map.svh"
module psi_irq_gen (
	// Clock and reset
	input  wire logic clk_sys,
	input  wire logic arst_n,
	input  wire logic ce,
	// Flags, controls and result
	psi_evt_if.irq    ev
);
	import psi_pkg::*;

	psi_irq_s st;
	psi_irq_s next_st;

	always_comb begin
		next_st = st;
		next_st.pending = ev.global_irq_enable & (|(ev.flags & ev.mask));
		next_st.irq_n   = ~(next_st.pending | ev.irq_force_test);
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			st <= '{pending: 1'b0, irq_n: 1'b1};
		end else if (ce) begin
			st <= next_st;
		end
	end

	assign ev.pending = st.pending;
	assign ev.irq_n   = st.irq_n;

	// ************************************************************
	// Checks
	// ************************************************************
	a_gate_off: assert property (@(posedge clk_sys) disable iff (!arst_n)
		ce && !ev.global_irq_enable && !ev.irq_force_test |=> ev.irq_n && !ev.pending)
		else $error("interrupt raised while disabled");

	a_force_low: assert property (@(posedge clk_sys) disable iff (!arst_n)
		ce && ev.irq_force_test |=> !ev.irq_n)
		else $error("test force did not assert interrupt");

	a_masked_event: assert property (@(posedge clk_sys) disable iff (!arst_n)
		ce && ev.global_irq_enable && |(ev.flags & ev.mask) |=> !ev.irq_n && ev.pending)
		else $error("enabled event did not interrupt");

	a_unmasked_quiet: assert property (@(posedge clk_sys) disable iff (!arst_n)
		ce && (ev.flags & ev.mask) == 4'h0 && !ev.irq_force_test |=> ev.irq_n)
		else $error("masked event interrupted");

endmodule // psi_irq_gen

/* psi_map.svh */
// Register map, field positions and reset values of the status and interrupt block
// Overview of operation
// - Status bit 8 reports negotiation versus manual mode
// - Status bit 7 mirrors the negotiation complete input
// - Status bit 5 shows reversed receive polarity, reads zero at 100 Mbps
// - Status bit 4 shows pause capability, reset zero
// - Error summary sets on any fault condition
// - Error clears only when fault sources read
// - Mask bit 7 enables negotiation done interrupt
// - Mask bit 6 enables speed change interrupt
// - Mask bit 5 enables duplex change interrupt
// - Mask bit 4 enables link change interrupt
// - Global enable bit 1 gates all event interrupts; test bit 0 bypasses it
// - Test bit 0 forces interrupt output low
// - Event bit 7 latches negotiation done, read clears
// - Event bit 6 latches speed change, read clears
// - Event bit 5 latches duplex change, read clears
// - Event bit 4 latches link change, read clears
// - Event bit 2 shows interrupt pending
`ifndef PSI_MAP_SVH
`define PSI_MAP_SVH

// ************************************************************
// Register offsets
// ************************************************************
`define PSI_ADDR_W       5
`define PSI_ADDR_STATUS2 5'h11
`define PSI_ADDR_MASK    5'h12
`define PSI_ADDR_EVENT   5'h13

// ************************************************************
// Field positions
// ************************************************************
`define PSI_B_DUPLEX     9
`define PSI_B_ANMODE     8
`define PSI_B_NEG_DONE   7
`define PSI_B_POL        5
`define PSI_B_PAUSE      4
`define PSI_B_ERR        3
`define PSI_EVT_MSB      7
`define PSI_EVT_LSB      4
`define PSI_B_PEND       2
`define PSI_B_GEN        1
`define PSI_B_FORCE      0
`define PSI_I_AN         3
`define PSI_I_SPEED      2
`define PSI_I_DUPLEX     1
`define PSI_I_LINK       0

// ************************************************************
// Reset values
// ************************************************************
`define PSI_RST_MASK     4'h0
`define PSI_RST_FLAGS    4'h0
`define PSI_RST_DATA     16'h0000

`endif

/* psi_mgr_model.sv */
// Station manager model that drives the register port
`timescale 1ns/1ps
module psi_mgr_model (
	// Clock
	input  wire logic               clk_sys,
	// Register port
	output psi_pkg::psi_addr_t      reg_addr,
	output psi_pkg::psi_data_t      reg_wdata,
	output logic                    reg_wr,
	output logic                    reg_rd,
	input  wire logic               reg_rvalid,
	input  wire psi_pkg::psi_data_t reg_rdata
);
	import psi_pkg::*;
	initial begin
		reg_addr = 5'h00;
		reg_wdata = 16'h0000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end
	// One write; the idle bus shows inverted values
	task automatic wr(input psi_addr_t a, input psi_data_t d);
		@(negedge clk_sys);
		reg_addr = a;
		reg_wdata = d & 16'h00f3;
		reg_wr = 1'b1;
		@(negedge clk_sys);
		reg_wr = 1'b0;
		reg_addr = ~a;
		reg_wdata = ~reg_wdata;
	endtask
	// One read, waiting a bounded time for the answer
	task automatic rd(input psi_addr_t a, output psi_data_t d);
		int n;
		@(negedge clk_sys);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge clk_sys);
		reg_rd = 1'b0;
		reg_addr = ~a;
		n = 0;
		while (reg_rvalid !== 1'b1 && n < 4) begin
			@(negedge clk_sys);
			n++;
		end
		d = (reg_rvalid === 1'b1) ? reg_rdata : 16'hxxxx;
	endtask
endmodule // psi_mgr_model

/* psi_pkg.sv */
// Types shared by the status and interrupt block
package psi_pkg;

	typedef logic [4:0]  psi_addr_t;
	typedef logic [15:0] psi_data_t;
	typedef logic [3:0]  psi_evt_t;

	// ************************************************************
	// State records
	// ************************************************************
	typedef struct packed {
		psi_evt_t  mask;
		logic      gen;
		logic      irq_force_test;
		logic      err;
		logic      pause;
		psi_data_t rdata;
		logic      rvalid;
	} psi_top_s;

	typedef struct packed {
		logic     primed;
		logic     prev_an;
		logic     prev_speed;
		logic     prev_duplex;
		logic     prev_link;
		psi_evt_t flags;
	} psi_evt_s;

	typedef struct packed {
		logic pending;
		logic irq_n;
	} psi_irq_s;

	function automatic logic psi_hit(input psi_addr_t addr, input psi_addr_t target);
		psi_hit = (addr == target);
	endfunction

endpackage

/* psi_top.sv */
// Upper status, interrupt mask and event registers with interrupt output
`timescale 1ns/1ps
`include "psi_map.svh"
module psi_top (
	// Clock and reset
	input  wire logic              clk_sys,
	input  wire logic              arst_n,
	input  wire logic              ce,
	// Register port
	input  wire psi_pkg::psi_addr_t reg_addr,
	input  wire psi_pkg::psi_data_t reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic                   reg_rvalid,
	output psi_pkg::psi_data_t     reg_rdata,
	// Line state
	input  wire logic              an_enabled,
	input  wire logic              an_complete,
	input  wire logic              speed_100,
	input  wire logic              duplex_full,
	input  wire logic              link_up,
	input  wire logic              polarity_rev,
	input  wire logic              pause_capable,
	// Fault sources
	input  wire logic              remote_fault,
	input  wire logic              jabber,
	input  wire logic              pd_fault,
	input  wire logic              fault_src_read,
	// Interrupt
	output logic                   mgmt_irq_n
);
	import psi_pkg::*;

	psi_top_s  st;
	psi_top_s  next_st;
	psi_data_t status_word;
	psi_data_t mask_word;
	psi_data_t event_word;
	logic      rd_event;
	logic      any_fault;

	psi_evt_if ev ();

	// ************************************************************
	// Event latching and interrupt generation
	// ************************************************************
	psi_evt_latch u_evt (
		.clk_sys     (clk_sys),
		.arst_n      (arst_n),
		.ce          (ce),
		.an_complete (an_complete),
		.speed_100   (speed_100),
		.duplex_full (duplex_full),
		.link_up     (link_up),
		.clear       (rd_event),
		.ev          (ev.evt)
	);

	psi_irq_gen u_irq (
		.clk_sys (clk_sys),
		.arst_n  (arst_n),
		.ce      (ce),
		.ev      (ev.irq)
	);

	assign ev.mask              = st.mask;
	assign ev.global_irq_enable = st.gen;
	assign ev.irq_force_test    = st.irq_force_test;

	// ************************************************************
	// Read words
	// ************************************************************
	always_comb begin
		status_word = `PSI_RST_DATA;
		status_word[`PSI_B_DUPLEX] = duplex_full;
		status_word[`PSI_B_ANMODE] = an_enabled;
		status_word[`PSI_B_NEG_DONE] = an_complete;
		// Polarity has no meaning at 100 Mbps, so it reads zero there
		status_word[`PSI_B_POL]    = polarity_rev & ~speed_100;
		status_word[`PSI_B_PAUSE]  = st.pause;
		status_word[`PSI_B_ERR]    = st.err;
	end

	always_comb begin
		mask_word = `PSI_RST_DATA;
		mask_word[`PSI_EVT_MSB:`PSI_EVT_LSB] = st.mask;
		mask_word[`PSI_B_GEN]   = st.gen;
		mask_word[`PSI_B_FORCE] = st.irq_force_test;
	end

	always_comb begin
		event_word = `PSI_RST_DATA;
		event_word[`PSI_EVT_MSB:`PSI_EVT_LSB] = ev.flags;
		event_word[`PSI_B_PEND] = ev.pending;
	end

	assign rd_event  = ce & reg_rd & psi_hit(reg_addr, `PSI_ADDR_EVENT);
	assign any_fault = remote_fault | jabber | pd_fault;

	// ************************************************************
	// Register state
	// ************************************************************
	always_comb begin
		next_st = st;
		next_st.pause  = pause_capable;
		// A summary read alone leaves the bit; a new fault wins over the clear
		next_st.err    = (st.err & ~fault_src_read) | any_fault;
		next_st.rvalid = reg_rd;
		if (reg_wr && psi_hit(reg_addr, `PSI_ADDR_MASK)) begin
			// Reserved positions are not stored and read back as zero
			next_st.mask           = reg_wdata[`PSI_EVT_MSB:`PSI_EVT_LSB];
			next_st.gen            = reg_wdata[`PSI_B_GEN];
			next_st.irq_force_test = reg_wdata[`PSI_B_FORCE];
		end
		if (reg_rd) begin
			case (reg_addr)
				`PSI_ADDR_STATUS2: begin
					next_st.rdata = status_word;
				end
				`PSI_ADDR_MASK: begin
					next_st.rdata = mask_word;
				end
				`PSI_ADDR_EVENT: begin
					next_st.rdata = event_word;
				end
				default: begin
					next_st.rdata = `PSI_RST_DATA;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			st <= '{mask: `PSI_RST_MASK, gen: 1'b0, irq_force_test: 1'b0, err: 1'b0,
				pause: 1'b0, rdata: `PSI_RST_DATA, rvalid: 1'b0};
		end else if (ce) begin
			st <= next_st;
		end
	end

	assign reg_rvalid = st.rvalid;
	assign reg_rdata  = st.rdata;
	assign mgmt_irq_n = ev.irq_n;

	// ************************************************************
	// Checks
	// ************************************************************
	sequence s_status_read;
		ce && reg_rd && reg_addr == `PSI_ADDR_STATUS2;
	endsequence

	sequence s_mask_write;
		ce && reg_wr && reg_addr == `PSI_ADDR_MASK;
	endsequence

	a_mode_bit: assert property (@(posedge clk_sys) disable iff (!arst_n)
		s_status_read |=> reg_rvalid && reg_rdata[`PSI_B_ANMODE] == $past(an_enabled))
		else $error("negotiation mode bit wrong");

	a_done_mirror: assert property (@(posedge clk_sys) disable iff (!arst_n)
		s_status_read |=> reg_rdata[`PSI_B_NEG_DONE] == $past(an_complete))
		else $error("negotiation complete bit wrong");

	a_polarity_bit: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(s_status_read and (!speed_100)) |=> reg_rdata[`PSI_B_POL] == $past(polarity_rev))
		else $error("polarity bit wrong");

	a_pause_bit: assert property (@(posedge clk_sys) disable iff (!arst_n)
		ce ##1 (ce && reg_rd && reg_addr == `PSI_ADDR_STATUS2)
		|=> reg_rdata[`PSI_B_PAUSE] == $past(pause_capable, 2))
		else $error("pause bit wrong");

	a_error_set: assert property (@(posedge clk_sys) disable iff (!arst_n)
		ce && any_fault |=> st.err)
		else $error("fault did not set error summary");

	a_error_kept: assert property (@(posedge clk_sys) disable iff (!arst_n)
		ce && st.err && !fault_src_read |=> st.err)
		else $error("error summary cleared without source read");

	a_mask_store: assert property (@(posedge clk_sys) disable iff (!arst_n)
		s_mask_write |=> st.mask == $past(reg_wdata[`PSI_EVT_MSB:`PSI_EVT_LSB]))
		else $error("mask write not stored");

	a_event_pending: assert property (@(posedge clk_sys) disable iff (!arst_n)
		ce && reg_rd && reg_addr == `PSI_ADDR_EVENT
		|=> reg_rdata[`PSI_B_PEND] == $past(ev.pending))
		else $error("pending bit wrong");

	a_enable_store: assert property (@(posedge clk_sys) disable iff (!arst_n)
		s_mask_write |=> st.gen == $past(reg_wdata[`PSI_B_GEN])
		&& st.irq_force_test == $past(reg_wdata[`PSI_B_FORCE]))
		else $error("enable or test bit not stored");

	a_duplex_bit: assert property (@(posedge clk_sys) disable iff (!arst_n)
		s_status_read |=> reg_rdata[`PSI_B_DUPLEX] == $past(duplex_full))
		else $error("duplex bit wrong");

	a_read_pulse: assert property (@(posedge clk_sys) disable iff (!arst_n)
		ce && !reg_rd |=> !reg_rvalid)
		else $error("read valid without a read");

	a_rdata_hold: assert property (@(posedge clk_sys) disable iff (!arst_n)
		!(ce && reg_rd) |=> $stable(reg_rdata))
		else $error("read data changed without a read");

	a_unmapped_zero: assert property (@(posedge clk_sys) disable iff (!arst_n)
		ce && reg_rd && reg_addr != `PSI_ADDR_STATUS2 && reg_addr != `PSI_ADDR_MASK
		&& reg_addr != `PSI_ADDR_EVENT |=> reg_rdata == `PSI_RST_DATA)
		else $error("unmapped read not zero");

	a_mask_reserved: assert property (@(posedge clk_sys) disable iff (!arst_n)
		ce && reg_rd && reg_addr == `PSI_ADDR_MASK
		|=> reg_rdata[15:8] == 8'h00 && reg_rdata[3:2] == 2'b00)
		else $error("reserved mask bits not zero");

	a_freeze_ctl: assert property (@(posedge clk_sys) disable iff (!arst_n)
		!ce |=> $stable(st.mask) && $stable(st.gen) && $stable(st.irq_force_test))
		else $error("controls changed while frozen");

endmodule // psi_top

/* psi_top_tb_top.sv */
// Self-checking bench for the status and interrupt block
`timescale 1ns/1ps
module psi_top_tb_top;
	import psi_pkg::*;
	logic      clk_sys = 1'b0;
	logic      arst_n = 1'b0;
	logic      ce = 1'b1;
	logic      an_enabled = 1'b0;
	logic      polarity_rev = 1'b0;
	logic      pause_capable = 1'b0;
	// Line inputs: an_complete, speed, duplex, link
	logic [3:0] evt_in = 4'h0;
	// Faults: remote, jabber, parallel detect, source read
	logic [3:0] flt = 4'h0;
	psi_addr_t reg_addr;
	psi_data_t reg_wdata;
	psi_data_t reg_rdata;
	psi_data_t rd_v;
	logic      reg_wr;
	logic      reg_rd;
	logic      reg_rvalid;
	logic      mgmt_irq_n;
	int        err_total = 0;
	int        check_count = 0;

	always #20 clk_sys = ~clk_sys;

	psi_top i_dut (.clk_sys(clk_sys), .arst_n(arst_n), .ce(ce), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rvalid(reg_rvalid),
		.reg_rdata(reg_rdata), .an_enabled(an_enabled), .an_complete(evt_in[3]),
		.speed_100(evt_in[2]), .duplex_full(evt_in[1]), .link_up(evt_in[0]),
		.polarity_rev(polarity_rev), .pause_capable(pause_capable), .remote_fault(flt[0]),
		.jabber(flt[1]), .pd_fault(flt[2]), .fault_src_read(flt[3]),
		.mgmt_irq_n(mgmt_irq_n));

	psi_mgr_model i_mgr (.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rvalid(reg_rvalid), .reg_rdata(reg_rdata));

	// ************************************************************
	// Helpers
	// ************************************************************
	task automatic chk(input psi_data_t seen, input psi_data_t exp);
		check_count++;
		if (seen !== exp) begin
			err_total++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic rdchk(input psi_addr_t a, input psi_data_t exp);
		i_mgr.rd(a, rd_v);
		chk(rd_v, exp);
	endtask
	task automatic irqchk(input logic e);
		chk({15'h0000, mgmt_irq_n}, {15'h0000, e});
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk_sys);
	endtask
	// Change one line input; negotiation done needs a rising edge
	task automatic kick(input int k);
		@(negedge clk_sys);
		evt_in[k] = ~evt_in[k];
		if (k == 3) begin
			@(negedge clk_sys);
			evt_in[k] = 1'b1;
		end
	endtask

	// ************************************************************
	// Scenarios
	// ************************************************************
	task automatic t_reset;
		irqchk(1'b1);
		rdchk(5'h11, 16'h0000);
		rdchk(5'h12, 16'h0000);
		rdchk(5'h13, 16'h0000);
		rdchk(5'h00, 16'h0000);
	endtask
	task automatic t_status;
		@(negedge clk_sys);
		an_enabled = 1'b1;
		polarity_rev = 1'b1;
		pause_capable = 1'b1;
		evt_in = 4'b1010;
		cyc(2);
		rdchk(5'h11, 16'h03b0);
		evt_in[2] = 1'b1;
		cyc(2);
		rdchk(5'h11, 16'h0390);
		rdchk(5'h13, 16'h00e0);
		rdchk(5'h13, 16'h0000);
	endtask
	task automatic t_error;
		for (int i = 0; i < 3; i++) begin
			@(negedge clk_sys);
			flt[i] = 1'b1;
			@(negedge clk_sys);
			flt[i] = 1'b0;
			rdchk(5'h11, 16'h0398);
			rdchk(5'h11, 16'h0398);
			@(negedge clk_sys);
			flt[3] = 1'b1;
			@(negedge clk_sys);
			flt[3] = 1'b0;
			rdchk(5'h11, 16'h0390);
		end
	endtask
	task automatic t_events;
		for (int k = 0; k < 4; k++) begin
			i_mgr.wr(5'h12, (16'h0010 << k) | 16'h0002);
			kick(k);
			cyc(2);
			irqchk(1'b0);
			rdchk(5'h13, (16'h0010 << k) | 16'h0004);
			cyc(1);
			irqchk(1'b1);
			i_mgr.wr(5'h12, 16'h00f2 & ~(16'h0010 << k));
			kick(k);
			cyc(2);
			irqchk(1'b1);
			rdchk(5'h13, 16'h0010 << k);
		end
	endtask
	task automatic t_gen_test;
		i_mgr.wr(5'h12, 16'h00f0);
		kick(0);
		cyc(2);
		irqchk(1'b1);
		rdchk(5'h12, 16'h00f0);
		rdchk(5'h13, 16'h0010);
		i_mgr.wr(5'h12, 16'hffff);
		rdchk(5'h12, 16'h00f3);
		irqchk(1'b0);
		rdchk(5'h13, 16'h0000);
		i_mgr.wr(5'h12, 16'h0000);
		cyc(1);
		irqchk(1'b1);
	endtask
	// Clock enable low freezes the line sampling; the change shows on resume
	task automatic t_freeze;
		i_mgr.wr(5'h12, 16'h0012);
		@(negedge clk_sys);
		ce = 1'b0;
		evt_in[0] = ~evt_in[0];
		cyc(3);
		irqchk(1'b1);
		ce = 1'b1;
		cyc(2);
		irqchk(1'b0);
		rdchk(5'h13, 16'h0014);
		i_mgr.wr(5'h12, 16'h0000);
	endtask
	// Reset in mid-run drops the forced interrupt and the controls
	task automatic t_rerun;
		i_mgr.wr(5'h12, 16'h0003);
		cyc(1);
		irqchk(1'b0);
		arst_n = 1'b0;
		cyc(2);
		irqchk(1'b1);
		arst_n = 1'b1;
		rdchk(5'h12, 16'h0000);
		rdchk(5'h13, 16'h0000);
	endtask

	// ************************************************************
	// Sequence and verdict
	// ************************************************************
	task automatic conclude;
		$display("Checks %0d, errors %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	initial begin
		cyc(20);
		arst_n = 1'b1;
		t_reset();
		t_status();
		t_error();
		t_events();
		t_gen_test();
		t_freeze();
		t_rerun();
		conclude();
	end
	// Watchdog: the sequence needs well under a thousand cycles
	initial begin
		#400000;
		err_total++;
		conclude();
	end
endmodule // psi_top_tb_top
